/* File: svr_pkg.sv */
// Shared constants and carriers for the voltage-id serial receiver.
// Assumes a 125 MHz device clock and a serial link of at most 3.4 Mbit/s.
package svr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Address byte layout
  localparam logic [2:0] ADDR_FIXED   = 3'h6;
  localparam int         ADDR_FIX_HI  = 7;
  localparam int         ADDR_FIX_LO  = 5;
  localparam int         SEL_CORE1    = 3;
  localparam int         SEL_CORE0    = 2;
  localparam int         SEL_NB       = 1;
  localparam int         DIR_BIT      = 0;

  // Data byte layout
  localparam int         PSI_BIT      = 7;
  localparam int         VID_HI       = 6;

  // Bit counting
  localparam logic [2:0] LAST_BIT     = 3'h7;
  localparam logic [2:0] FIRST_BIT    = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset
  localparam logic [6:0] VID_RST      = 7'h00;
  localparam logic       PSI_N_RST    = 1'h1;
  localparam logic [4:0] SYNC_RST     = 5'h03;

  ////////////////////////////////////////////////////////////////////////////
  // Link timing
  localparam int         MCLK_KHZ     = 125000;
  localparam int         BIT_RATE_KHZ = 3400;
  // Shortest clock-high phase in device cycles, rounded down
  localparam int         HIGH_CYC     = MCLK_KHZ / BIT_RATE_KHZ / 2;

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic       psi_n;
    logic [6:0] vid;
  } svr_rail_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_AACK,
    ST_DATA,
    ST_DACK,
    ST_WSTOP,
    ST_IGN
  } svr_state_t;

endpackage

/* File: svr_sync.sv */
// Two-stage level synchroniser, one chain per bit.
// Assumes inputs that may change at any time relative to clk.
`timescale 1ns/1ps
module svr_sync #(
  parameter int         W       = 5,
  parameter logic [4:0] RST_VAL = 5'h00
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge clk)
      begin
        if (!rst_n)
        begin
          meta_r[i] <= RST_VAL[i];
          q[i]      <= RST_VAL[i];
        end
        else
        begin
          meta_r[i] <= d[i];
          q[i]      <= meta_r[i];
        end
      end
    end
  endgenerate

endmodule

/* File: svr_link_cap.sv */
// Bit capture on the serial clock's own domain.
// Assumes the link clock may stop between frames; a toggle marks each bit.
`timescale 1ns/1ps
module svr_link_cap (
  input  wire logic lclk,
  input  wire logic rst_n,
  input  wire logic sda,
  output logic      bit_r,
  output logic      tog_r
);

  // Async reset: link clock may be stopped while the device is in reset
  always_ff @(posedge lclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bit_r <= 1'h1;
      tog_r <= 1'h0;
    end
    else
    begin
      // Sampled at clock rise, held stable a full bit for the other side
      bit_r <= sda;
      tog_r <= ~tog_r;
    end
  end

endmodule

/* File: svr_receiver.sv */
// Receive-only two-wire voltage-id command slave.
// Assumes the serial pins come from the processor; the link clock is its
// own clock domain, and mode inputs come from logic on MCLK.
`timescale 1ns/1ps
module svr_receiver (
  input  wire logic              MCLK,
  input  wire logic              RSTN,
  input  wire logic              VID_SERIAL_CLOCK,
  input  wire logic              VID_SERIAL_DATA_I,
  output logic                   VID_SERIAL_DATA_O,
  output logic                   VID_SERIAL_DATA_OE_N,
  input  wire logic              COMBINED_MODE_SENSE_A,
  input  wire logic              COMBINED_MODE_SENSE_B,
  input  wire logic              PROGRAMMING_MODE,
  input  wire logic              BOOT_DONE,
  input  wire logic              OFFSET_OPTION,
  output svr_pkg::svr_rail_t     CORE0_RAIL,
  output svr_pkg::svr_rail_t     CORE1_RAIL,
  output svr_pkg::svr_rail_t     NB_RAIL,
  output logic [2:0]             RAIL_UPDATE,
  output logic [2:0]             FORCED_PWM,
  output logic [2:0]             OFFSET_ON,
  output logic                   TWO_PHASE,
  output logic                   COMBINED_MODE,
  output logic                   BUS_IDLE
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  svr_pkg::svr_state_t state_r;
  svr_pkg::svr_state_t state_nxt;
  logic                lbit;
  logic                ltog;
  logic [4:0]          sync_q;
  logic                scl;
  logic                sda;
  logic                tog;
  logic                scl_p_r;
  logic                sda_p_r;
  logic                tog_p_r;
  logic                start_ev;
  logic                stop_ev;
  logic                scl_fall;
  logic                bit_ev;
  logic [2:0]          cnt_r;
  logic [7:0]          sh_r;
  logic [7:0]          sh_nxt;
  logic                byte_done;
  logic                ack_drv_r;
  logic                ack_end;
  logic [2:0]          sel_r;
  svr_pkg::svr_rail_t  data_r;
  logic                comb;

  // Address match on the fixed upper bits only
  function automatic logic addr_hit(input logic [7:0] b);
    addr_hit = (b[svr_pkg::ADDR_FIX_HI:svr_pkg::ADDR_FIX_LO] == svr_pkg::ADDR_FIXED);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Link-domain bit capture and crossings
  svr_link_cap u_cap (
    .lclk  (VID_SERIAL_CLOCK),
    .rst_n (RSTN),
    .sda   (VID_SERIAL_DATA_I),
    .bit_r (lbit),
    .tog_r (ltog)
  );

  svr_sync #(
    .W       (5),
    .RST_VAL (svr_pkg::SYNC_RST)
  ) u_sync (
    .clk   (MCLK),
    .rst_n (RSTN),
    .d     ({COMBINED_MODE_SENSE_B, COMBINED_MODE_SENSE_A, ltog,
             VID_SERIAL_DATA_I, VID_SERIAL_CLOCK}),
    .q     (sync_q)
  );

  assign scl  = sync_q[0];
  assign sda  = sync_q[1];
  assign tog  = sync_q[2];
  assign comb = sync_q[3] | sync_q[4];

  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
    begin
      scl_p_r <= 1'h1;
      sda_p_r <= 1'h1;
      tog_p_r <= 1'h0;
    end
    else
    begin
      scl_p_r <= scl;
      sda_p_r <= sda;
      tog_p_r <= tog;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus conditions
  assign start_ev = scl & scl_p_r & sda_p_r & ~sda;
  assign stop_ev  = scl & scl_p_r & ~sda_p_r & sda;
  assign scl_fall = scl_p_r & ~scl;
  // Captured bit is stable a whole bit period after its toggle lands
  assign bit_ev   = tog ^ tog_p_r;
  assign sh_nxt   = {sh_r[6:0], lbit};
  assign byte_done = bit_ev && (cnt_r == svr_pkg::LAST_BIT);
  assign ack_end  = scl_fall && ack_drv_r;

  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
      BUS_IDLE <= 1'h1;
    else
      BUS_IDLE <= scl & sda;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      svr_pkg::ST_ADDR:
        if (byte_done)
        begin
          if (addr_hit(sh_nxt) && !PROGRAMMING_MODE)
            state_nxt = svr_pkg::ST_AACK;
          else
            state_nxt = svr_pkg::ST_IGN;
        end
      svr_pkg::ST_AACK:
        if (ack_end)
          state_nxt = svr_pkg::ST_DATA;
      svr_pkg::ST_DATA:
        if (byte_done)
          state_nxt = svr_pkg::ST_DACK;
      svr_pkg::ST_DACK:
        if (ack_end)
          state_nxt = svr_pkg::ST_WSTOP;
      default:
        state_nxt = state_r;
    endcase
    // Bus conditions override any phase
    if (start_ev)
      state_nxt = svr_pkg::ST_ADDR;
    else if (stop_ev)
      state_nxt = svr_pkg::ST_IDLE;
  end

  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
      state_r <= svr_pkg::ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // Bit counter and shifter
  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
    begin
      cnt_r <= svr_pkg::FIRST_BIT;
      sh_r  <= 8'h00;
    end
    else if (start_ev || ack_end)
      cnt_r <= svr_pkg::FIRST_BIT;
    else if (bit_ev && (state_r == svr_pkg::ST_ADDR || state_r == svr_pkg::ST_DATA))
    begin
      cnt_r <= cnt_r + 3'h1;
      sh_r  <= sh_nxt;
    end
  end

  // Latch rail selects and data byte
  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
    begin
      sel_r  <= 3'h0;
      data_r <= '{psi_n: svr_pkg::PSI_N_RST, vid: svr_pkg::VID_RST};
    end
    else if (byte_done && state_r == svr_pkg::ST_ADDR)
      sel_r <= sh_nxt[svr_pkg::SEL_CORE1:svr_pkg::SEL_NB];
    else if (byte_done && state_r == svr_pkg::ST_DATA)
      data_r <= sh_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Acknowledge drive: low from the fall after bit 8 to the fall after bit 9
  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
      ack_drv_r <= 1'h0;
    else if (start_ev || stop_ev)
      ack_drv_r <= 1'h0;
    else if (scl_fall && (state_r == svr_pkg::ST_AACK || state_r == svr_pkg::ST_DACK))
      ack_drv_r <= ~ack_drv_r;
  end

  // Only ever pulls low; never returns data
  assign VID_SERIAL_DATA_O    = 1'h0;
  assign VID_SERIAL_DATA_OE_N = ~ack_drv_r;

  ////////////////////////////////////////////////////////////////////////////
  // Rail update at STOP after a full command
  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
    begin
      CORE0_RAIL  <= '{psi_n: svr_pkg::PSI_N_RST, vid: svr_pkg::VID_RST};
      CORE1_RAIL  <= '{psi_n: svr_pkg::PSI_N_RST, vid: svr_pkg::VID_RST};
      NB_RAIL     <= '{psi_n: svr_pkg::PSI_N_RST, vid: svr_pkg::VID_RST};
      RAIL_UPDATE <= 3'h0;
    end
    else
    begin
      RAIL_UPDATE <= 3'h0;
      if (stop_ev && state_r == svr_pkg::ST_WSTOP)
      begin
        if (sel_r[1])
        begin
          CORE0_RAIL     <= data_r;
          RAIL_UPDATE[1] <= 1'h1;
        end
        if (sel_r[2] && !comb)
        begin
          CORE1_RAIL     <= data_r;
          RAIL_UPDATE[2] <= 1'h1;
        end
        if (sel_r[0])
        begin
          NB_RAIL        <= data_r;
          RAIL_UPDATE[0] <= 1'h1;
        end
      end
    end
  end

  // Forced PWM/offset follow each rail's power-save bit gated by BOOT_DONE/OFFSET_OPTION; two-phase: core 0's bit if combined; combined mode: either sense pin
  always_ff @(posedge MCLK)
  begin
    if (!RSTN)
    begin
      FORCED_PWM    <= 3'h0;
      OFFSET_ON     <= 3'h0;
      TWO_PHASE     <= 1'h0;
      COMBINED_MODE <= 1'h0;
    end
    else
    begin
      FORCED_PWM    <= {CORE1_RAIL.psi_n, CORE0_RAIL.psi_n, NB_RAIL.psi_n}
                       & {3{BOOT_DONE}};
      OFFSET_ON     <= {CORE1_RAIL.psi_n, CORE0_RAIL.psi_n, NB_RAIL.psi_n}
                       & {3{OFFSET_OPTION}};
      TWO_PHASE     <= comb & CORE0_RAIL.psi_n;
      COMBINED_MODE <= comb;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_addr_byte;
    state_r == svr_pkg::ST_ADDR && byte_done;
  endsequence

  // Eight cycles is well short of any clock-high phase at the fastest rate
  sequence s_ack_pulse;
    ack_drv_r [*8];
  endsequence

  a_start_addr: assert property (@(posedge MCLK) disable iff (!RSTN)
    start_ev |=> state_r == svr_pkg::ST_ADDR && cnt_r == svr_pkg::FIRST_BIT)
    else $error("START did not open an address phase");

  a_stop_idle: assert property (@(posedge MCLK) disable iff (!RSTN)
    stop_ev && !start_ev |=> state_r == svr_pkg::ST_IDLE && !ack_drv_r)
    else $error("STOP did not return to idle");

  a_addr_match: assert property (@(posedge MCLK) disable iff (!RSTN)
    s_addr_byte |=> (state_r == svr_pkg::ST_AACK)
                    == (addr_hit(sh_r) && !$past(PROGRAMMING_MODE) && !$past(start_ev)
                        && !$past(stop_ev)))
    else $error("Address decision wrong");

  a_miss_quiet: assert property (@(posedge MCLK) disable iff (!RSTN)
    state_r == svr_pkg::ST_IGN |-> VID_SERIAL_DATA_OE_N)
    else $error("Data driven after address miss");

  a_drive_ack: assert property (@(posedge MCLK) disable iff (!RSTN)
    !VID_SERIAL_DATA_OE_N |-> !VID_SERIAL_DATA_O
      && (state_r == svr_pkg::ST_AACK || state_r == svr_pkg::ST_DACK))
    else $error("Data driven outside acknowledge");

  a_ack_held: assert property (@(posedge MCLK) disable iff (!RSTN)
    !VID_SERIAL_DATA_OE_N && scl && !scl_p_r |-> (!VID_SERIAL_DATA_OE_N) [*8])
    else $error("Acknowledge released early");

  a_ack_span: assert property (@(posedge MCLK) disable iff (!RSTN)
    $rose(ack_drv_r) && !start_ev |-> s_ack_pulse)
    else $error("Acknowledge shorter than a clock-high phase");

  a_nb_update: assert property (@(posedge MCLK) disable iff (!RSTN)
    stop_ev && state_r == svr_pkg::ST_WSTOP && sel_r[0]
      |=> NB_RAIL == $past(data_r) && RAIL_UPDATE[0])
    else $error("Northbridge rail not updated");

  a_comb_core1: assert property (@(posedge MCLK) disable iff (!RSTN)
    comb |=> !RAIL_UPDATE[2])
    else $error("Core 1 written in combined mode");

  a_psi_mode: assert property (@(posedge MCLK) disable iff (!RSTN)
    BOOT_DONE && !CORE0_RAIL.psi_n && $stable(CORE0_RAIL) |=> !FORCED_PWM[1] && !TWO_PHASE)
    else $error("Power-save low did not give skip mode");

endmodule

/* File: svr_master_model.sv */
// Behavioural serial master standing in for the processor.
// Assumes a free-running 15 ns tick; the serial clock idles high between frames.
`timescale 1ns/1ps
module svr_master_model #(
  parameter int PH = 10
) (
  input  wire logic lclk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_o,
  output logic      sda_oe
);
  initial
  begin
    scl    = 1'b1;
    sda_o  = 1'b1;
    sda_oe = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge lclk);
  endtask

  // Data moves mid low phase, late enough for the ack release to land first
  task automatic pulse(input logic b, input logic drv, output logic seen);
    tick(PH / 2);
    sda_oe = drv;
    sda_o  = b;
    tick(PH - PH / 2);
    scl = 1'b1;
    tick(PH);
    seen = sda;
    scl = 1'b0;
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      pulse(b[i], 1'b1, s);
    pulse(1'b1, 1'b0, s);
    ack = ~s;
  endtask

  // Whole command; the data byte may be left out to stop early
  task automatic frame(input logic [7:0] a, input logic [7:0] d, input logic wd,
                       output logic ack_a, output logic ack_d);
    sda_oe = 1'b1;
    sda_o  = 1'b1;
    tick(PH);
    sda_o = 1'b0;
    tick(PH);
    scl = 1'b0;
    send_byte({a[7:1], 1'b0}, ack_a);
    ack_d = 1'b0;
    if (wd)
      send_byte(d, ack_d);
    tick(PH / 2);
    sda_oe = 1'b1;
    sda_o  = 1'b0;
    tick(PH - PH / 2);
    scl = 1'b1;
    tick(PH);
    sda_o = 1'b1;
    tick(PH);
  endtask
endmodule

/* File: svr_receiver_tb.sv */
// Self-checking bench for the voltage-id serial receiver.
// Assumes the master model drives the wire push-pull; a pull-up holds it when free.
`timescale 1ns/1ps
module svr_receiver_tb;
  typedef struct packed {
    logic [2:0] upd;
    logic [7:0] data;
    logic       boot;
    logic       opt;
    logic       comb;
  } svr_note_t;

  logic               mclk = 1'b0;
  logic               lclk = 1'b0;
  logic               rstn = 1'b1;
  logic               sense_a = 1'b0;
  logic               sense_b = 1'b0;
  logic               prog = 1'b0;
  logic               boot = 1'b0;
  logic               opt = 1'b0;
  logic               scl;
  logic               m_sda;
  logic               m_oe;
  logic               sda_w;
  logic               sda_do;
  logic               sda_oe_n;
  svr_pkg::svr_rail_t core0;
  svr_pkg::svr_rail_t core1;
  svr_pkg::svr_rail_t nb;
  logic [2:0]         upd;
  logic [2:0]         fpwm;
  logic [2:0]         offs;
  logic               two_ph;
  logic               comb_mode;
  logic               bus_idle;
  integer             seed = 41;
  int                 n_mismatch = 0;
  int                 total_checks = 0;
  svr_note_t          notes[$];
  svr_note_t          m;

  always #4 mclk = ~mclk;
  always #7.5 lclk = ~lclk;

  // Device pull-down wins; otherwise the master, else the pull-up
  assign sda_w = (sda_oe_n === 1'b0) ? sda_do : (m_oe ? m_sda : 1'b1);

  svr_master_model i_svr_master_model (.lclk(lclk), .sda(sda_w), .scl(scl),
                                       .sda_o(m_sda), .sda_oe(m_oe));

  svr_receiver i_svr_receiver (
    .MCLK(mclk), .RSTN(rstn), .VID_SERIAL_CLOCK(scl), .VID_SERIAL_DATA_I(sda_w),
    .VID_SERIAL_DATA_O(sda_do), .VID_SERIAL_DATA_OE_N(sda_oe_n),
    .COMBINED_MODE_SENSE_A(sense_a), .COMBINED_MODE_SENSE_B(sense_b),
    .PROGRAMMING_MODE(prog), .BOOT_DONE(boot), .OFFSET_OPTION(opt),
    .CORE0_RAIL(core0), .CORE1_RAIL(core1), .NB_RAIL(nb), .RAIL_UPDATE(upd),
    .FORCED_PWM(fpwm), .OFFSET_ON(offs), .TWO_PHASE(two_ph),
    .COMBINED_MODE(comb_mode), .BUS_IDLE(bus_idle));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // One command with random data; the expected update goes on the queue
  task automatic cmd(input logic [2:0] hi, input logic [2:0] sel, input logic wd);
    logic [31:0] r;
    logic        acked;
    logic        aa;
    logic        ad;
    svr_note_t   n;
    r = $random(seed);
    @(posedge mclk);
    boot <= r[9];
    opt  <= r[10];
    repeat (4) @(posedge mclk);
    acked  = (hi === svr_pkg::ADDR_FIXED) && !prog;
    n.comb = sense_a | sense_b;
    n.upd  = n.comb ? (sel & 3'h3) : sel;
    n.data = r[7:0];
    n.boot = r[9];
    n.opt  = r[10];
    if (acked && wd && n.upd != 3'h0)
      notes.push_back(n);
    i_svr_master_model.frame({hi, r[8], sel, 1'b0}, r[7:0], wd, aa, ad);
    chk(aa, acked);
    chk(ad, acked & wd);
    repeat (12) @(posedge mclk);
    #1;
    chk(notes.size(), 0);
    chk(sda_oe_n, 1'b1);
    chk(bus_idle, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Result watcher: each update pulse takes the oldest note
  always @(posedge mclk)
  begin
    #1;
    if (rstn && upd !== 3'h0)
    begin
      if (notes.size() == 0)
        chk(upd, 3'h0);
      else
      begin
        m = notes.pop_front();
        chk(upd, m.upd);
        if (m.upd[2])
          chk(core1, m.data);
        if (m.upd[1])
          chk(core0, m.data);
        if (m.upd[0])
          chk(nb, m.data);
        @(posedge mclk);
        #1;
        for (int i = 0; i < 3; i++)
          if (m.upd[i])
          begin
            chk(fpwm[i], m.data[7] & m.boot);
            chk(offs[i], m.data[7] & m.opt);
          end
        if (m.upd[1])
          chk(two_ph, m.comb & m.data[7]);
      end
    end
  end

  initial
  begin
    #400000;
    n_mismatch++;
    close_out();
  end

  initial
  begin
    // A real falling edge, so the link-side flops with async reset clear too
    rstn <= 1'b0;
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    #1;
    chk({core0, core1, nb}, {3{svr_pkg::PSI_N_RST, svr_pkg::VID_RST}});
    chk({sda_oe_n, bus_idle, upd}, 5'h18);
    repeat (6) @(posedge mclk);
    for (int s = 0; s < 8; s++)
      cmd(3'h6, 3'(s), 1'b1);
    $display("Test rail select done");
    for (int k = 0; k < 2; k++)
    begin
      @(posedge mclk);
      sense_a <= (k == 0);
      sense_b <= (k == 1);
      repeat (8) @(posedge mclk);
      #1;
      chk(comb_mode, 1'b1);
      cmd(3'h6, 3'h7, 1'b1);
    end
    @(posedge mclk);
    sense_a <= 1'b0;
    sense_b <= 1'b0;
    repeat (8) @(posedge mclk);
    #1;
    chk(comb_mode, 1'b0);
    $display("Test combined mode done");
    for (int h = 0; h < 8; h++)
      if (h != 6)
        cmd(3'(h), 3'h7, 1'b1);
    $display("Test foreign address done");
    @(posedge mclk);
    prog <= 1'b1;
    cmd(3'h6, 3'h7, 1'b1);
    @(posedge mclk);
    prog <= 1'b0;
    cmd(3'h6, 3'h7, 1'b0);
    $display("Test refusals done");
    close_out();
  end
endmodule
